// ===== rtl/ebi_defs.svh
// Register offsets, field positions and reset values of the external bus interface.
// Assumes inclusion by bare name from the package only; the register file uses its macros without including it.
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH

`define EBI_OFS_CTRL       12'h000
`define EBI_OFS_ADDR       12'h004
`define EBI_OFS_WDATA      12'h008
`define EBI_OFS_RDATA      12'h00C
`define EBI_OFS_STATUS     12'h010
`define EBI_OFS_BANK_BASE  12'h020
`define EBI_OFS_BANK_LAST  12'h03C

`define EBI_CTRL_GO        0
`define EBI_CTRL_WRITE     1
`define EBI_STAT_BUSY      0
`define EBI_STAT_ERR       1
`define EBI_STAT_GRANT     2
`define EBI_STAT_BOOT_LSB  4
`define EBI_BANK_WID_LSB   0
`define EBI_BANK_CYC_LSB   4
`define EBI_BANK_SIZE_LSB  8

`define EBI_RST_WIDTH      2'h1
`define EBI_RST_CYCLES     4'hF
`define EBI_RST_SIZE       3'h7

`endif

// ===== rtl/ebi_pkg.sv
// Types shared by the external bus interface modules.
// Assumes nothing beyond the defines header.
package ebi_pkg;
  `include "ebi_defs.svh"

  typedef enum logic [1:0] {
    EBI_W8  = 2'h0,
    EBI_W16 = 2'h1,
    EBI_W32 = 2'h2
  } ebi_width_e;

  typedef enum logic [1:0] {
    EBI_BOOT_NAND = 2'h0,
    EBI_BOOT_16   = 2'h1,
    EBI_BOOT_32   = 2'h2,
    EBI_BOOT_TEST = 2'h3
  } ebi_boot_e;

  typedef enum logic [2:0] {
    EBI_ST_IDLE   = 3'h0,
    EBI_ST_SETUP  = 3'h1,
    EBI_ST_STROBE = 3'h3,
    EBI_ST_END    = 3'h2,
    EBI_ST_GRANT  = 3'h6
  } ebi_state_e;

  typedef logic [7:0][1:0] ebi_widths_t;
  typedef logic [7:0][3:0] ebi_cycles_t;
  typedef logic [7:0][2:0] ebi_sizes_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        go;
    logic        go_wr;
    logic [29:0] addr;
    logic [31:0] wdata;
    ebi_widths_t width;
    ebi_cycles_t cycles;
    ebi_sizes_t  size;
  } ebi_regs_s;

  typedef struct packed {
    ebi_state_e  state;
    logic [1:0]  boot;
    logic [1:0]  beat;
    logic [3:0]  cnt;
    logic [2:0]  bank;
    logic [1:0]  width;
    logic        wr;
    logic [26:0] base;
    logic [31:0] wdata;
    logic [26:0] addr;
    logic        addr_oe_low;
    logic [31:0] dout;
    logic        data_oe_low;
    logic [7:0]  cs_low;
    logic        we_low;
    logic        oe_low;
    logic        strobe_oe_low;
    logic        grant_low;
    logic [31:0] rdata;
    logic        busy;
    logic        err;
  } ebi_eng_s;
endpackage : ebi_pkg

// ===== rtl/ebi_cfg_if.sv
// Carrier between the register file and the bus engine.
// Assumes both ends share clock and reset.
interface ebi_cfg_if;
  import ebi_pkg::*;
  logic              go;
  logic              go_wr;
  logic [29:0]       addr;
  logic [31:0]       wdata;
  ebi_widths_t       width;
  ebi_cycles_t       cycles;
  ebi_sizes_t        size;
  logic              busy;
  logic              err;
  logic              granted;
  logic [1:0]        boot;
  logic [31:0]       rdata;

  modport regs (output go, go_wr, addr, wdata, width, cycles, size,
                input  busy, err, granted, boot, rdata);
  modport eng  (input  go, go_wr, addr, wdata, width, cycles, size,
                output busy, err, granted, boot, rdata);
endinterface : ebi_cfg_if

// ===== rtl/ebi_regs.sv
// APB register file of the external bus interface.
// Assumes an APB master; answers with pready in the second access cycle.
module ebi_regs
  import ebi_pkg::*;
(
  // Clock and reset
  input  wire logic  clock_i,
  input  wire logic  rst_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Engine side
  ebi_cfg_if.regs          cfg
);
  import ebi_pkg::*;

  ebi_regs_s st_ff;
  ebi_regs_s nxt_st;

  function automatic logic ebi_mapped(input logic [11:0] a);
    ebi_mapped = (a[1:0] == 2'h0) &&
                 (a <= `EBI_OFS_STATUS || (a >= `EBI_OFS_BANK_BASE && a <= `EBI_OFS_BANK_LAST));
  endfunction : ebi_mapped

  function automatic logic [31:0] ebi_read(input logic [11:0] a, input ebi_regs_s s);
    logic [2:0] b;
    b = a[4:2];
    ebi_read = 32'h0;
    case (a)
      `EBI_OFS_ADDR:   ebi_read = {2'h0, s.addr};
      `EBI_OFS_WDATA:  ebi_read = s.wdata;
      `EBI_OFS_RDATA:  ebi_read = cfg.rdata;
      `EBI_OFS_STATUS: begin
        ebi_read[`EBI_STAT_BUSY]  = cfg.busy;
        ebi_read[`EBI_STAT_ERR]   = cfg.err;
        ebi_read[`EBI_STAT_GRANT] = cfg.granted;
        ebi_read[`EBI_STAT_BOOT_LSB +: 2] = cfg.boot;
      end
      default: begin
        if (a >= `EBI_OFS_BANK_BASE && a <= `EBI_OFS_BANK_LAST) begin
          ebi_read[`EBI_BANK_WID_LSB +: 2]  = s.width[b];
          ebi_read[`EBI_BANK_CYC_LSB +: 4]  = s.cycles[b];
          ebi_read[`EBI_BANK_SIZE_LSB +: 3] = s.size[b];
        end
      end
    endcase
  endfunction : ebi_read

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.go      = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.pready  = psel_i & penable_i & ~st_ff.pready;
    if (psel_i && penable_i && !st_ff.pready) begin
      nxt_st.prdata  = ebi_read(paddr_i, st_ff);
      nxt_st.pslverr = ~ebi_mapped(paddr_i);
    end
    // Write lands on the edge where pready is seen high
    if (psel_i && penable_i && st_ff.pready && pwrite_i && ebi_mapped(paddr_i)) begin
      case (paddr_i)
        `EBI_OFS_CTRL: begin
          // A start while busy is dropped; status shows busy
          nxt_st.go    = pwdata_i[`EBI_CTRL_GO] & ~cfg.busy;
          nxt_st.go_wr = pwdata_i[`EBI_CTRL_WRITE];
        end
        `EBI_OFS_ADDR:  nxt_st.addr  = pwdata_i[29:0];
        `EBI_OFS_WDATA: nxt_st.wdata = pwdata_i;
        default: begin
          if (paddr_i >= `EBI_OFS_BANK_BASE) begin
            nxt_st.width[paddr_i[4:2]]  = pwdata_i[`EBI_BANK_WID_LSB +: 2];
            nxt_st.cycles[paddr_i[4:2]] = pwdata_i[`EBI_BANK_CYC_LSB +: 4];
            nxt_st.size[paddr_i[4:2]]   = pwdata_i[`EBI_BANK_SIZE_LSB +: 3];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff        <= '0;
      st_ff.width  <= {8{`EBI_RST_WIDTH}};
      st_ff.cycles <= {8{`EBI_RST_CYCLES}};
      st_ff.size   <= {8{`EBI_RST_SIZE}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o   = st_ff.prdata;
  assign pready_o   = st_ff.pready;
  assign pslverr_o  = st_ff.pslverr;
  assign cfg.go     = st_ff.go;
  assign cfg.go_wr  = st_ff.go_wr;
  assign cfg.addr   = st_ff.addr;
  assign cfg.wdata  = st_ff.wdata;
  assign cfg.width  = st_ff.width;
  assign cfg.cycles = st_ff.cycles;
  assign cfg.size   = st_ff.size;
endmodule : ebi_regs

// ===== rtl/ebi_top.sv
// External static memory bus interface: APB registers start single-word
// accesses that run as one or more bus beats on the external pins.
// Assumes pins already synchronous to clock_i; the pad ring resolves enables.
//
// Added by the designer: register access over APB and the register offsets.
module ebi_top
  import ebi_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Straps
  input  wire logic [1:0]  boot_mode_pins_i,
  // Address and data pins
  output logic [26:0]      addr_o,
  output logic             addr_oe_low_o,
  input  wire logic [31:0] data_i,
  output logic [31:0]      data_o,
  output logic             data_oe_low_o,
  // Selects and strobes
  output logic [7:0]       bank_select_low_o,
  output logic             write_strobe_low_o,
  output logic             read_strobe_low_o,
  output logic             strobe_oe_low_o,
  // Cycle stretch and bus hand-over
  input  wire logic        cycle_stretch_low_i,
  input  wire logic        bus_hold_request_low_i,
  output logic             bus_hold_grant_low_o
);
  import ebi_pkg::*;

  ebi_cfg_if cfg ();

  ebi_eng_s st_ff;
  ebi_eng_s nxt_st;

  ebi_regs u_regs (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .paddr_i   (paddr_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .cfg       (cfg)
  );

  // Bank 0 width comes from the straps, not from software
  function automatic logic [1:0] ebi_eff_width(input logic [2:0] bank, input logic [1:0] boot,
                                              input logic [1:0] prog);
    if (bank == 3'h0) begin
      ebi_eff_width = (boot == EBI_BOOT_16) ? EBI_W16 : EBI_W32;
    end else begin
      ebi_eff_width = (prog == EBI_W8 || prog == EBI_W16) ? prog : EBI_W32;
    end
  endfunction : ebi_eff_width

  // Region is 1 MB shifted left by the size code; code 7 spans all 128 MB
  function automatic logic ebi_in_region(input logic [26:0] ofs, input logic [2:0] code);
    ebi_in_region = ((ofs[26:20] >> code) == 7'h0);
  endfunction : ebi_in_region

  function automatic logic [26:0] ebi_beat_ofs(input logic [1:0] w, input logic [1:0] beat);
    case (w)
      EBI_W8:  ebi_beat_ofs = {25'h0, beat};
      EBI_W16: ebi_beat_ofs = {25'h0, beat[0], 1'b0};
      default: ebi_beat_ofs = 27'h0;
    endcase
  endfunction : ebi_beat_ofs

  function automatic logic ebi_last_beat(input logic [1:0] w, input logic [1:0] beat);
    case (w)
      EBI_W8:  ebi_last_beat = (beat == 2'h3);
      EBI_W16: ebi_last_beat = (beat == 2'h1);
      default: ebi_last_beat = 1'b1;
    endcase
  endfunction : ebi_last_beat

  // Narrow beats use the low lanes of the data bus
  function automatic logic [31:0] ebi_lane_wr(input logic [1:0] w, input logic [1:0] beat,
                                             input logic [31:0] d);
    case (w)
      EBI_W8:  ebi_lane_wr = {24'h0, d[{beat, 3'h0} +: 8]};
      EBI_W16: ebi_lane_wr = {16'h0, d[{beat[0], 4'h0} +: 16]};
      default: ebi_lane_wr = d;
    endcase
  endfunction : ebi_lane_wr

  function automatic logic [31:0] ebi_lane_rd(input logic [1:0] w, input logic [1:0] beat,
                                             input logic [31:0] acc, input logic [31:0] din);
    ebi_lane_rd = acc;
    case (w)
      EBI_W8:  ebi_lane_rd[{beat, 3'h0} +: 8] = din[7:0];
      EBI_W16: ebi_lane_rd[{beat[0], 4'h0} +: 16] = din[15:0];
      default: ebi_lane_rd = din;
    endcase
  endfunction : ebi_lane_rd

  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      EBI_ST_IDLE: begin
        // Hand-over wins over a start in the same cycle
        if (!bus_hold_request_low_i) begin
          nxt_st.state         = EBI_ST_GRANT;
          nxt_st.addr_oe_low   = 1'b1;
          nxt_st.data_oe_low   = 1'b1;
          nxt_st.strobe_oe_low = 1'b1;
          nxt_st.grant_low     = 1'b0;
          nxt_st.busy          = st_ff.busy | cfg.go;
          if (cfg.go) begin
            nxt_st.wr    = cfg.go_wr;
            nxt_st.bank  = cfg.addr[29:27];
            nxt_st.base  = cfg.addr[26:0];
            nxt_st.wdata = cfg.wdata;
          end
        end else if (cfg.go || st_ff.busy) begin
          if (cfg.go) begin
            nxt_st.wr    = cfg.go_wr;
            nxt_st.bank  = cfg.addr[29:27];
            nxt_st.base  = cfg.addr[26:0];
            nxt_st.wdata = cfg.wdata;
          end
          nxt_st.busy  = 1'b1;
          nxt_st.beat  = 2'h0;
          nxt_st.width = ebi_eff_width(nxt_st.bank, st_ff.boot, cfg.width[nxt_st.bank]);
          // Outside the bank region or in test mode: refuse, no pins move
          if (st_ff.boot == EBI_BOOT_TEST ||
              !ebi_in_region(nxt_st.base, cfg.size[nxt_st.bank])) begin
            nxt_st.busy = 1'b0;
            nxt_st.err  = 1'b1;
          end else begin
            nxt_st.err   = 1'b0;
            nxt_st.state = EBI_ST_SETUP;
            nxt_st.addr  = nxt_st.base + ebi_beat_ofs(nxt_st.width, 2'h0);
            nxt_st.cs_low[nxt_st.bank] = 1'b0;
            if (nxt_st.wr) begin
              nxt_st.dout        = ebi_lane_wr(nxt_st.width, 2'h0, nxt_st.wdata);
              nxt_st.data_oe_low = 1'b0;
            end
          end
        end
      end
      EBI_ST_SETUP: begin
        nxt_st.state = EBI_ST_STROBE;
        nxt_st.cnt   = cfg.cycles[st_ff.bank];
        if (st_ff.wr) begin
          nxt_st.we_low = 1'b0;
        end else begin
          nxt_st.oe_low = 1'b0;
        end
      end
      EBI_ST_STROBE: begin
        if (st_ff.cnt != 4'h0) begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end else if (cycle_stretch_low_i) begin
          nxt_st.state  = EBI_ST_END;
          nxt_st.we_low = 1'b1;
          nxt_st.oe_low = 1'b1;
          nxt_st.cs_low = 8'hFF;
          if (!st_ff.wr) begin
            nxt_st.rdata = ebi_lane_rd(st_ff.width, st_ff.beat, st_ff.rdata, data_i);
          end
        end
      end
      EBI_ST_END: begin
        // Write data held through this cycle for hold time
        nxt_st.data_oe_low = 1'b1;
        if (ebi_last_beat(st_ff.width, st_ff.beat)) begin
          nxt_st.state = EBI_ST_IDLE;
          nxt_st.busy  = 1'b0;
        end else begin
          nxt_st.state = EBI_ST_SETUP;
          nxt_st.beat  = st_ff.beat + 2'h1;
          nxt_st.addr  = st_ff.base + ebi_beat_ofs(st_ff.width, st_ff.beat + 2'h1);
          nxt_st.cs_low[st_ff.bank] = 1'b0;
          if (st_ff.wr) begin
            nxt_st.dout        = ebi_lane_wr(st_ff.width, st_ff.beat + 2'h1, st_ff.wdata);
            nxt_st.data_oe_low = 1'b0;
          end
        end
      end
      EBI_ST_GRANT: begin
        if (bus_hold_request_low_i) begin
          // Take the bus back; a start held during the grant runs next
          nxt_st.state         = EBI_ST_IDLE;
          nxt_st.grant_low     = 1'b1;
          nxt_st.addr_oe_low   = 1'b0;
          nxt_st.strobe_oe_low = 1'b0;
        end else if (cfg.go) begin
          nxt_st.busy  = 1'b1;
          nxt_st.wr    = cfg.go_wr;
          nxt_st.bank  = cfg.addr[29:27];
          nxt_st.base  = cfg.addr[26:0];
          nxt_st.wdata = cfg.wdata;
        end
      end
      default: begin
        nxt_st.state = EBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_ff               <= '0;
      st_ff.state         <= EBI_ST_IDLE;
      st_ff.cs_low        <= 8'hFF;
      st_ff.we_low        <= 1'b1;
      st_ff.oe_low        <= 1'b1;
      st_ff.data_oe_low   <= 1'b1;
      st_ff.grant_low     <= 1'b1;
      st_ff.addr_oe_low   <= 1'b0;
      st_ff.strobe_oe_low <= 1'b0;
      st_ff.boot          <= boot_mode_pins_i;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign addr_o             = st_ff.addr;
  assign addr_oe_low_o      = st_ff.addr_oe_low;
  assign data_o             = st_ff.dout;
  assign data_oe_low_o      = st_ff.data_oe_low;
  assign bank_select_low_o  = st_ff.cs_low;
  assign write_strobe_low_o = st_ff.we_low;
  assign read_strobe_low_o  = st_ff.oe_low;
  assign strobe_oe_low_o    = st_ff.strobe_oe_low;
  assign bus_hold_grant_low_o = st_ff.grant_low;

  assign cfg.busy    = st_ff.busy;
  assign cfg.err     = st_ff.err;
  assign cfg.granted = ~st_ff.grant_low;
  assign cfg.boot    = st_ff.boot;
  assign cfg.rdata   = st_ff.rdata;
endmodule : ebi_top

// ===== verif/ebi_ext_mem.sv
// Static memory with a wait-state source, on the far side of the bus pins.
// Assumes active-low selects and strobes; one word per address low byte.
module ebi_ext_mem (
  // Clock
  input  wire logic        clock_i,
  // Device pins
  input  wire logic [26:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [7:0]  sel_low_i,
  input  wire logic        we_low_i,
  input  wire logic        re_low_i,
  // Answers
  input  wire logic [3:0]  stall_i,
  output logic [31:0]      rdata_o,
  output logic             stretch_low_o
);
  logic [31:0] mem [256];
  logic [31:0] last_ff;
  logic [3:0]  cnt_ff;
  wire         hit = sel_low_i != 8'hFF;
  wire         on  = hit && !(we_low_i && re_low_i);

  // Released bus flips every cycle, so a late sample never matches
  assign rdata_o = (hit && !re_low_i) ? mem[addr_i[7:0]] : ~last_ff;
  assign stretch_low_o = !(on && cnt_ff < stall_i);

  always_ff @(posedge clock_i) begin
    last_ff <= rdata_o;
    cnt_ff  <= on ? cnt_ff + 4'h1 : 4'h0;
    if (hit && !we_low_i) begin
      mem[addr_i[7:0]] <= wdata_i;
    end
  end
endmodule : ebi_ext_mem

// ===== verif/ebi_top_assertions.sv
// Pin-level checks of the external bus interface.
// Assumes binding into ebi_top; sees its ports only.
module ebi_top_assertions (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Pins
  input wire logic [26:0] addr_o,
  input wire logic        addr_oe_low_o,
  input wire logic [31:0] data_o,
  input wire logic        data_oe_low_o,
  input wire logic [7:0]  bank_select_low_o,
  input wire logic        write_strobe_low_o,
  input wire logic        read_strobe_low_o,
  input wire logic        strobe_oe_low_o,
  input wire logic        cycle_stretch_low_i,
  input wire logic        bus_hold_request_low_i,
  input wire logic        bus_hold_grant_low_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire strobe_on = !write_strobe_low_o || !read_strobe_low_o;

  AST_GRANT_FLOAT: assert property (!bus_hold_grant_low_o |-> addr_oe_low_o && data_oe_low_o && strobe_oe_low_o)
    else $error("pins driven while bus granted");
  AST_GRANT_CAUSE: assert property ($fell(bus_hold_grant_low_o) |-> !$past(bus_hold_request_low_i))
    else $error("grant without request");
  AST_GRANT_DROP: assert property (bus_hold_request_low_i && !bus_hold_grant_low_o |=> bus_hold_grant_low_o)
    else $error("grant kept after request left");
  AST_ONE_BANK: assert property ($onehot0(~bank_select_low_o))
    else $error("more than one bank selected");
  AST_STROBE_EXCL: assert property (write_strobe_low_o || read_strobe_low_o)
    else $error("both strobes active");
  AST_WRITE_DRIVES: assert property (!write_strobe_low_o |-> !data_oe_low_o && bank_select_low_o != 8'hFF)
    else $error("write strobe without driven data or select");
  AST_READ_FLOATS: assert property (!read_strobe_low_o |-> data_oe_low_o && bank_select_low_o != 8'hFF)
    else $error("data driven during read");
  // Wait is honoured only once the programmed count ran out, never skipped
  AST_STRETCH_HOLD: assert property (strobe_on && !cycle_stretch_low_i |=> strobe_on)
    else $error("cycle ended while stretch low");
  AST_ADDR_STEADY: assert property (strobe_on && $past(strobe_on) |-> $stable(addr_o) && $stable(bank_select_low_o))
    else $error("address moved inside strobe");
  AST_WDATA_STEADY: assert property (!write_strobe_low_o |-> $stable(data_o))
    else $error("write data moved inside strobe");

  COV_WRITE: cover property (!write_strobe_low_o);
  COV_READ_WAIT: cover property (!read_strobe_low_o && !cycle_stretch_low_i);
  COV_GRANT: cover property (!bus_hold_grant_low_o);
endmodule : ebi_top_assertions

bind ebi_top ebi_top_assertions ebi_top_assertions_i (.clock_i, .rst_i, .addr_o, .addr_oe_low_o, .data_o,
  .data_oe_low_o, .bank_select_low_o, .write_strobe_low_o, .read_strobe_low_o, .strobe_oe_low_o,
  .cycle_stretch_low_i, .bus_hold_request_low_i, .bus_hold_grant_low_o);

// ===== verif/tb_top.sv
// Testbench of the external bus interface: APB tasks drive accesses,
// a memory model answers on the pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [1:0]  boot = 2'h1;
  logic [3:0]  stall = 4'h0;
  logic        req_low = 1'b1;
  logic [31:0] prdata, rdat, dout;
  logic [26:0] addr;
  logic [7:0]  sel_low, last_sel;
  logic        ready, slverr, aoe, doe, soe, we_low, re_low, st_low, gnt_low, last_err;
  int          fails = 0, cmp_count = 0, run = 0, last_len = 0, rrun = 0, last_rlen = 0;

  always #2 clock_i = ~clock_i;

  ebi_top ebi_top_i (.clock_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o(prdata), .pready_o(ready), .pslverr_o(slverr), .boot_mode_pins_i(boot),
    .addr_o(addr), .addr_oe_low_o(aoe), .data_i(rdat), .data_o(dout), .data_oe_low_o(doe),
    .bank_select_low_o(sel_low), .write_strobe_low_o(we_low), .read_strobe_low_o(re_low),
    .strobe_oe_low_o(soe), .cycle_stretch_low_i(st_low), .bus_hold_request_low_i(req_low),
    .bus_hold_grant_low_o(gnt_low));

  ebi_ext_mem ext_mem_i (.clock_i, .addr_i(addr), .wdata_i(dout), .sel_low_i(sel_low),
    .we_low_i(we_low), .re_low_i(re_low), .stall_i(stall), .rdata_o(rdat), .stretch_low_o(st_low));

  // Length of the last write and read strobe, in cycles, and the select under the write
  always @(posedge clock_i) begin
    if (we_low === 1'b0) begin
      run      <= run + 1;
      last_sel <= sel_low;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    // Stretch must lengthen the strobe, not only keep the data right
    if (re_low === 1'b0) rrun <= rrun + 1;
    else if (rrun != 0) begin
      last_rlen <= rrun;
      rrun <= 0;
    end
  end

  task stop_test;
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (ready !== 1'b1 && n < 40);
    r = prdata;
    last_err = slverr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (ready !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask : rd

  task go(input int bk, input int o, input logic w, input logic [31:0] d);
    wr(12'h004, {2'h0, bk[2:0], o[26:0]});
    wr(12'h008, d);
    wr(12'h000, {30'h0, w, 1'b1});
  endtask : go

  task idle(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(12'h010, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    if (s[0] !== 1'b0) begin
      fails++;
      stop_test();
    end
  endtask : idle

  task reset(input logic [1:0] b);
    @(posedge clock_i);
    rst_i <= 1'b1;
    boot <= b;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask : reset

  // Write then read one word; ew is the effective width code
  task xfer(input int bk, input logic [1:0] rw, input int ew, input int cy, input logic [3:0] st);
    logic [31:0] d, s, m;
    int bw;
    d = 32'h8C4A2E10 ^ (bk * 32'h01010101);
    bw = 1 << ew;
    m = 32'hFFFFFFFF >> (32 - 8 * bw);
    wr(12'h020 + 12'(4 * bk), {24'h0, 4'(cy), 2'h0, rw});
    stall <= 4'h0;
    go(bk, 16 * (bk + 1), 1'b1, d);
    idle(s);
    chk(s & 32'h3, 32'h0);
    chk(32'(last_len), 32'(cy + 1));
    chk({24'h0, last_sel}, {24'h0, ~(8'h01 << bk)});
    for (int b = 0; b < 4 / bw; b++) begin
      chk(ext_mem_i.mem[16 * (bk + 1) + b * bw] & m, (d >> (8 * bw * b)) & m);
    end
    stall <= st;
    go(bk, 16 * (bk + 1), 1'b0, 32'h0);
    idle(s);
    rd(12'h00C, s);
    chk(s, d);
    chk(32'(last_rlen), 32'((cy > st) ? cy + 1 : st + 1));
  endtask : xfer

  initial begin
    logic [31:0] s;
    int b;
    for (int i = 0; i < 4; i++) begin
      b = 3 - i;
      reset(b[1:0]);
      rd(12'h010, s);
      chk(s, {26'h0, b[1:0], 4'h0});
      if (b == 3) begin
        go(0, 0, 1'b1, 32'h0);
        idle(s);
        chk(s & 32'h2, 32'h2);
      end else begin
        xfer(0, 2'h2, (b == 1) ? 1 : 2, b, 4'(b + 3));
      end
    end
    for (int n = 1; n < 8; n++) begin
      rd(12'h020 + 12'(4 * n), s);
      chk(s, 32'h7F1);
    end
    rd(12'h014, s);
    chk({s[31:1], last_err}, 32'h1);
    xfer(1, 2'h3, 2, 15, 4'h0);
    xfer(2, 2'h1, 1, 1, 4'h4);
    xfer(3, 2'h0, 0, 2, 4'h5);
    // Region edge: 1MB bank, first offset past it is refused
    wr(12'h030, 32'h2);
    go(4, 32'h100000, 1'b1, 32'h0BAD0BAD);
    idle(s);
    chk(s & 32'h2, 32'h2);
    go(4, 32'h0FFFF0, 1'b1, 32'h1234ABCD);
    idle(s);
    chk(s & 32'h2, 32'h0);
    chk(ext_mem_i.mem[8'hF0], 32'h1234ABCD);
    chk({24'h0, last_sel}, 32'hEF);
    req_low <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk({28'h0, gnt_low, aoe, doe, soe}, 32'h7);
    go(1, 32, 1'b1, 32'h600DF00D);
    rd(12'h010, s);
    chk(s & 32'h4, 32'h4);
    chk(ext_mem_i.mem[32], 32'h8D4B2F11);
    req_low <= 1'b1;
    idle(s);
    chk(ext_mem_i.mem[32], 32'h600DF00D);
    chk({24'h0, last_sel}, 32'hFD);
    stop_test();
  end
endmodule : tb_top
